/* design/eiu_top.sv */
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "eiu_params.svh"
module eiu_top (
    input  wire logic                   i_clk,
    input  wire logic                   i_reset_n,
    input  wire logic [`EIU_ADDR_W-1:0] i_addr,
    input  wire logic [7:0]             i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [7:0]             o_rdata,
    input  wire logic                   i_global_irq_en,
    input  wire logic                   i_irq_ack,
    input  eiu_pkg::eiu_vector_t        i_ack_vector,
    input  wire logic                   i_ext_irq_line_a,
    input  wire logic                   i_ext_irq_line_b,
    input  wire logic [7:0]             i_pin_change_inputs,
    output logic                        o_irq_req,
    output eiu_pkg::eiu_vector_t        o_irq_vector
);
    import eiu_pkg::*;

    // Software-visible registers.
    logic [7:0]  core_ctrl_q;     // Sense fields of both lines.
    logic [7:0]  en_mask_q;       // Per-source enable bits.
    logic [7:0]  pc_mask_q;       // Per-pin change enables.
    logic        line_a_flag_q;   // Pending edge event on line a.
    logic        line_b_flag_q;   // Pending edge event on line b.
    logic        pc_flag_q;       // Pending pin change event.
    logic        line_a_flag_d;
    logic        line_b_flag_d;
    logic        pc_flag_d;

    // Output registers.
    logic [7:0]  rdata_q;
    logic        irq_req_q;
    eiu_vector_t irq_vec_q;
    logic        irq_req_d;
    eiu_vector_t irq_vec_d;

    // Decoded fields and detector results.
    eiu_sense_t  sense_a;         // Mode of line a.
    eiu_sense_t  sense_b;         // Mode of line b.
    logic        level_a;         // Line a is in level mode.
    logic        level_b;         // Line b is in level mode.
    logic        ev_a;            // Qualifying edge on line a.
    logic        ev_b;            // Qualifying edge on line b.
    logic        low_a;           // Line a currently low.
    logic        low_b;           // Line b currently low.
    logic        pc_change;       // Masked change on the group.
    logic        wr_ctrl;
    logic        wr_en;
    logic        wr_flag;
    logic        wr_pcm;
    logic        req_a;           // Enabled request of line a.
    logic        req_b;           // Enabled request of line b.
    logic        req_pc;          // Enabled pin change request.
    logic [7:0]  rd_mux;          // Read value before the register.

    // Sense fields taken from the control register.
    always_comb begin
        sense_a = eiu_sense_t'(core_ctrl_q[`EIU_SENSE_A_LSB +: 2]);
        sense_b = eiu_sense_t'(core_ctrl_q[`EIU_SENSE_B_LSB +: 2]);
        level_a = (sense_a == EIU_SENSE_LOW);
        level_b = (sense_b == EIU_SENSE_LOW);
    end

    // Line a detector; the raw pad level is used, so a pin driven
    // as an output by its own port still raises events.
    eiu_sense_line u_line_a (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_pin     (i_ext_irq_line_a),
        .i_mode    (sense_a),
        .o_event   (ev_a),
        .o_low     (low_a)
    );

    // Line b detector, built the same way as line a.
    eiu_sense_line u_line_b (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_pin     (i_ext_irq_line_b),
        .i_mode    (sense_b),
        .o_event   (ev_b),
        .o_low     (low_b)
    );

    // Change detector for the eight-pin group.
    eiu_pin_change u_pin_change (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_pins    (i_pin_change_inputs),
        .i_mask    (pc_mask_q),
        .o_change  (pc_change)
    );

    // Write strobes for each register.
    always_comb begin
        wr_ctrl = i_wr & (i_addr == `EIU_OFS_CORE_CTRL);
        wr_en   = i_wr & (i_addr == `EIU_OFS_EN_MASK);
        wr_flag = i_wr & (i_addr == `EIU_OFS_FLAG_BANK);
        wr_pcm  = i_wr & (i_addr == `EIU_OFS_PC_MASK);
    end

    // Control register keeps only the two sense fields.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            core_ctrl_q <= `EIU_CTRL_RST;
        end else if (wr_ctrl) begin
            core_ctrl_q <= i_wdata & `EIU_CTRL_USED;
        end
    end

    // Enable mask keeps the three source enables.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            en_mask_q <= `EIU_EN_RST;
        end else if (wr_en) begin
            en_mask_q <= i_wdata & `EIU_SRC_USED;
        end
    end

    // Pin change mask, one enable per input pin.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pc_mask_q <= `EIU_PCM_RST;
        end else if (wr_pcm) begin
            pc_mask_q <= i_wdata;
        end
    end

    // Next flag values. A new event beats a clear in the same
    // cycle, so no request is lost. Level mode forces the flag
    // of that line to zero.
    always_comb begin
        line_a_flag_d = line_a_flag_q;
        line_b_flag_d = line_b_flag_q;
        pc_flag_d     = pc_flag_q;
        // Clear by writing ones to the flag register.
        if (wr_flag) begin
            if (i_wdata[`EIU_BIT_LINE_A]) begin
                line_a_flag_d = 1'b0;
            end
            if (i_wdata[`EIU_BIT_LINE_B]) begin
                line_b_flag_d = 1'b0;
            end
            if (i_wdata[`EIU_BIT_PC]) begin
                pc_flag_d = 1'b0;
            end
        end
        // Clear on handler entry for the acknowledged vector.
        if (i_irq_ack) begin
            case (i_ack_vector)
                EIU_VEC_LINE_A:     line_a_flag_d = 1'b0;
                EIU_VEC_LINE_B:     line_b_flag_d = 1'b0;
                EIU_VEC_PIN_CHANGE: pc_flag_d     = 1'b0;
                default:            ;
            endcase
        end
        // Events set the flags and win over any clear.
        if (ev_a) begin
            line_a_flag_d = 1'b1;
        end
        if (ev_b) begin
            line_b_flag_d = 1'b1;
        end
        if (pc_change) begin
            pc_flag_d = 1'b1;
        end
        // Level-sensed lines never hold a flag.
        if (level_a) begin
            line_a_flag_d = 1'b0;
        end
        if (level_b) begin
            line_b_flag_d = 1'b0;
        end
    end

    // Flag bank storage.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            line_a_flag_q <= 1'b0;
            line_b_flag_q <= 1'b0;
            pc_flag_q     <= 1'b0;
        end else begin
            line_a_flag_q <= line_a_flag_d;
            line_b_flag_q <= line_b_flag_d;
            pc_flag_q     <= pc_flag_d;
        end
    end

    // Requests gated by each source enable and the global enable.
    // A level-sensed line requests for as long as it reads low.
    always_comb begin
        req_a  = i_global_irq_en & en_mask_q[`EIU_BIT_LINE_A]
                 & (level_a ? low_a : line_a_flag_q);
        req_b  = i_global_irq_en & en_mask_q[`EIU_BIT_LINE_B]
                 & (level_b ? low_b : line_b_flag_q);
        req_pc = i_global_irq_en & en_mask_q[`EIU_BIT_PC]
                 & pc_flag_q;
    end

    // Vector selection: line a first, then line b, then pin change.
    always_comb begin
        irq_req_d = req_a | req_b | req_pc;
        if (req_a) begin
            irq_vec_d = EIU_VEC_LINE_A;
        end else if (req_b) begin
            irq_vec_d = EIU_VEC_LINE_B;
        end else if (req_pc) begin
            irq_vec_d = EIU_VEC_PIN_CHANGE;
        end else begin
            irq_vec_d = EIU_VEC_NONE;
        end
    end

    // Registered request and vector towards the core.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_req_q <= 1'b0;
            irq_vec_q <= EIU_VEC_NONE;
        end else begin
            irq_req_q <= irq_req_d;
            irq_vec_q <= irq_vec_d;
        end
    end

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        rd_mux = `EIU_ZERO_BYTE;
        case (i_addr)
            `EIU_OFS_CORE_CTRL: rd_mux = core_ctrl_q;
            `EIU_OFS_EN_MASK:   rd_mux = en_mask_q;
            `EIU_OFS_FLAG_BANK: begin
                rd_mux[`EIU_BIT_LINE_B] = line_b_flag_q;
                rd_mux[`EIU_BIT_LINE_A] = line_a_flag_q;
                rd_mux[`EIU_BIT_PC]     = pc_flag_q;
            end
            `EIU_OFS_PC_MASK:   rd_mux = pc_mask_q;
            default:            rd_mux = `EIU_ZERO_BYTE;
        endcase
    end

    // Read data stands for exactly one cycle after the strobe.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q <= `EIU_ZERO_BYTE;
        end else if (i_rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= `EIU_ZERO_BYTE;
        end
    end

    // Top outputs come straight from flip-flops.
    assign o_rdata      = rdata_q;
    assign o_irq_req    = irq_req_q;
    assign o_irq_vector = irq_vec_q;

endmodule // eiu_top

/* design/eiu_params.svh */
`ifndef EIU_PARAMS_SVH
`define EIU_PARAMS_SVH

// Register offsets on the local register port.
`define EIU_ADDR_W        3
`define EIU_OFS_CORE_CTRL 3'h0
`define EIU_OFS_EN_MASK   3'h1
`define EIU_OFS_FLAG_BANK 3'h2
`define EIU_OFS_PC_MASK   3'h3

// Bit positions shared by the mask and flag registers.
`define EIU_BIT_LINE_B    7
`define EIU_BIT_LINE_A    6
`define EIU_BIT_PC        5

// Lowest bit of each two-bit sense field.
`define EIU_SENSE_A_LSB   0
`define EIU_SENSE_B_LSB   2

// Reset values and implemented-bit masks.
`define EIU_CTRL_RST      8'h00
`define EIU_EN_RST        8'h00
`define EIU_FLAG_RST      8'h00
`define EIU_PCM_RST       8'h00
`define EIU_CTRL_USED     8'h0F
`define EIU_SRC_USED      8'hE0
`define EIU_ZERO_BYTE     8'h00
`define EIU_FILL_W        3
`endif

/* design/eiu_pkg.sv */
package eiu_pkg;

    // Sense modes in their hardware encoding, 00 up to 11.
    typedef enum logic [1:0] {
        EIU_SENSE_LOW,
        EIU_SENSE_ANY,
        EIU_SENSE_FALL,
        EIU_SENSE_RISE
    } eiu_sense_t;

    // Vector codes handed to the core.
    typedef enum logic [1:0] {
        EIU_VEC_NONE,
        EIU_VEC_LINE_A,
        EIU_VEC_LINE_B,
        EIU_VEC_PIN_CHANGE
    } eiu_vector_t;

    // Returns one when a sample pair qualifies as an edge event.
    function automatic logic eiu_edge_hit(eiu_sense_t mode,
                                          logic       prev,
                                          logic       cur);
        case (mode)
            EIU_SENSE_ANY:  return prev ^ cur;
            EIU_SENSE_FALL: return prev & ~cur;
            EIU_SENSE_RISE: return ~prev & cur;
            default:        return 1'b0;
        endcase
    endfunction

endpackage

/* design/eiu_sense_line.sv */
`timescale 1ns/1ns
`include "eiu_params.svh"
module eiu_sense_line (
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_pin,
    input  eiu_pkg::eiu_sense_t    i_mode,
    output logic                   o_event,
    output logic                   o_low
);
    import eiu_pkg::*;

    logic                  sync1_q;  // First synchroniser stage.
    logic                  sync2_q;  // Second synchroniser stage.
    logic                  prev_q;   // Previous synchronised sample.
    logic [`EIU_FILL_W-1:0] fill_q;  // Marks a filled pipeline.

    // Two-stage synchroniser followed by the history sample.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q  <= 1'b1;
        end else begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Blocks false edges until real samples fill the pipeline.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fill_q <= '0;
        end else begin
            fill_q <= {fill_q[`EIU_FILL_W-2:0], 1'b1};
        end
    end

    // Edge decode compares the newest sample with the one before.
    always_comb begin
        o_event = fill_q[`EIU_FILL_W-1]
                  & eiu_edge_hit(i_mode, prev_q, sync2_q);
        o_low   = fill_q[`EIU_FILL_W-1] & ~sync2_q;
    end

endmodule // eiu_sense_line

/* design/eiu_pin_change.sv */
`timescale 1ns/1ns
`include "eiu_params.svh"
module eiu_pin_change (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [7:0]  i_pins,
    input  wire logic [7:0]  i_mask,
    output logic             o_change
);
    logic [7:0] prev_q;    // Last sampled pin levels.
    logic       primed_q;  // High once prev_q holds a real sample.

    // History register of all eight inputs.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prev_q   <= `EIU_ZERO_BYTE;
            primed_q <= 1'b0;
        end else begin
            prev_q   <= i_pins;
            primed_q <= 1'b1;
        end
    end

    // Any masked pin that differs from its history is a change.
    // The compare is purely combinational on the raw input.
    always_comb begin
        o_change = primed_q
                   & (|((i_pins ^ prev_q) & i_mask));
    end

endmodule // eiu_pin_change

/* testbench/eiu_top_asserts.sv */
`timescale 1ns/1ns
`include "eiu_params.svh"
// Checks the top ports against a shadow copy of the written setup.
module eiu_top_asserts
    import eiu_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_reset_n,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       i_global_irq_en,
    input wire logic       i_irq_ack,
    input eiu_pkg::eiu_vector_t i_ack_vector,
    input wire logic       i_ext_irq_line_a,
    input wire logic       i_ext_irq_line_b,
    input wire logic [7:0] i_pin_change_inputs,
    input wire logic       o_irq_req,
    input eiu_pkg::eiu_vector_t o_irq_vector
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    logic [7:0] ctrl_q; // Shadow of the sense control register.
    logic [7:0] en_q;   // Shadow of the enable mask register.
    logic [7:0] pcm_q;  // Shadow of the pin-change mask register.

    // Follows register writes so the properties know the setup.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= 8'h00;
            en_q   <= 8'h00;
            pcm_q  <= 8'h00;
        end else if (i_wr) begin
            case (i_addr)
                `EIU_OFS_CORE_CTRL: ctrl_q <= i_wdata;
                `EIU_OFS_EN_MASK:   en_q   <= i_wdata;
                `EIU_OFS_PC_MASK:   pcm_q  <= i_wdata;
                default: ;
            endcase
        end
    end

    // A source stays enabled with no ack and no write for four cycles.
    sequence s_quiet(en);
        (en && i_global_irq_en && !i_irq_ack && !i_wr) [*4];
    endsequence
    // Line a falls while it is set up for falling edges.
    sequence s_fall_a;
        $fell(i_ext_irq_line_a) && ctrl_q[1:0] == 2'b10 && en_q[6];
    endsequence
    // Line b rises while it is set up for rising edges.
    sequence s_rise_b;
        $rose(i_ext_irq_line_b) && ctrl_q[3:2] == 2'b11 && en_q[7];
    endsequence

    a_en_read_back:
        assert property ($past(i_rd) && $past(i_addr) == `EIU_OFS_EN_MASK
            |-> o_rdata == ($past(en_q) & 8'hE0))
        else $error("enable mask read back wrong");
    a_req_vector:
        assert property (o_irq_req |-> o_irq_vector != EIU_VEC_NONE)
        else $error("request without a vector");
    a_gie_blocks:
        assert property (!$past(i_global_irq_en) |-> !o_irq_req)
        else $error("request while globally disabled");
    a_enables_off:
        assert property ($past(en_q[7:5]) == 3'b000 |-> !o_irq_req)
        else $error("request with all sources disabled");
    a_level_a:
        assert property ((!i_ext_irq_line_a && ctrl_q[1:0] == 2'b00
            && en_q[6] && i_global_irq_en) [*5] |-> o_irq_req)
        else $error("level request on line a missing");
    a_fall_a:
        assert property (s_fall_a ##1 s_quiet(en_q[6])
            |-> o_irq_req && o_irq_vector == EIU_VEC_LINE_A)
        else $error("falling edge on line a not requested");
    a_rise_b:
        assert property (s_rise_b ##1 s_quiet(en_q[7]) |-> o_irq_req)
        else $error("rising edge on line b not requested");
    a_pc_req:
        assert property ((|((i_pin_change_inputs
            ^ $past(i_pin_change_inputs)) & pcm_q)) && en_q[5]
            ##1 s_quiet(en_q[5]) |-> o_irq_req)
        else $error("pin change not requested");
endmodule // eiu_top_asserts

/* testbench/eiu_pin_model.sv */
`timescale 1ns/1ns
// Drives the two dedicated lines and the pin-change group as pads.
module eiu_pin_model (
    input  wire logic  i_clk,
    output logic       o_line_a,
    output logic       o_line_b,
    output logic [7:0] o_pins
);
    logic [9:0] pads_q = 10'h300; // Line b, line a, group; lines idle high.

    assign {o_line_b, o_line_a, o_pins} = pads_q;

    // Sets a new pad pattern after an edge and holds it four cycles.
    task automatic drive(input logic [9:0] v);
        @(posedge i_clk);
        pads_q <= v;
        repeat (4) @(posedge i_clk);
    endtask
endmodule // eiu_pin_model

/* testbench/eiu_top_test.sv */
`timescale 1ns/1ns
`include "eiu_params.svh"
// Counts one comparison and reports a mismatch at once.
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("unexpected at %0t got %h exp %h", $time, (g), (e)); \
    end \
end
module eiu_top_test;
    import eiu_pkg::*;
    logic        i_clk;
    logic        i_reset_n;
    logic [2:0]  i_addr;
    logic [7:0]  i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [7:0]  o_rdata;
    logic        i_global_irq_en;
    logic        i_irq_ack;
    eiu_vector_t i_ack_vector;
    logic        i_ext_irq_line_a;
    logic        i_ext_irq_line_b;
    logic [7:0]  i_pin_change_inputs;
    logic        o_irq_req;
    eiu_vector_t o_irq_vector;
    int          err_total;
    int          total_checks;
    int          cycles;

    always #5 i_clk = ~i_clk;

    // The pads stand in for pins the device may drive itself.
    eiu_pin_model pm (.i_clk(i_clk), .o_line_a(i_ext_irq_line_a),
        .o_line_b(i_ext_irq_line_b), .o_pins(i_pin_change_inputs));
    eiu_top dut (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_global_irq_en, .i_irq_ack, .i_ack_vector,
        .i_ext_irq_line_a, .i_ext_irq_line_b, .i_pin_change_inputs,
        .o_irq_req, .o_irq_vector);

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Cuts a hang short well after the tests should have ended.
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            close_out();
        end
    end

    // One register write cycle.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask

    // One read cycle; the data is judged in the cycle after the strobe.
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 `CHK(o_rdata, e)
    endtask

    // Core enters a handler; outputs settle one edge later.
    task automatic ack(input eiu_vector_t v);
        @(posedge i_clk);
        i_irq_ack    <= 1'b1;
        i_ack_vector <= v;
        @(posedge i_clk);
        i_irq_ack    <= 1'b0;
        @(posedge i_clk);
        #1;
    endtask

    // Sets the core's global enable.
    task automatic set_gie(input logic v);
        @(posedge i_clk);
        i_global_irq_en <= v;
    endtask

    // Reset values, then all ones written everywhere, unmapped included.
    task automatic t_regs;
        logic [7:0] exp_v [8] = '{8'h0F, 8'hE0, 8'h00, 8'hFF,
                                  8'h00, 8'h00, 8'h00, 8'h00};
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
        for (int a = 0; a < 8; a++) wr(3'(a), 8'hFF);
        for (int a = 0; a < 8; a++) rd(3'(a), exp_v[a]);
        for (int a = 0; a < 8; a++) wr(3'(a), 8'h00);
        $display("t_regs finished");
    endtask

    // Every edge mode on each line, with falling then rising pads.
    task automatic t_edge_modes;
        logic [7:0] f;
        for (int l = 0; l < 2; l++) begin
            for (int m = 1; m < 4; m++) begin
                f = l ? 8'h80 : 8'h40;
                wr(`EIU_OFS_CORE_CTRL, 8'(m << (2 * l)));
                pm.drive(l ? 10'h100 : 10'h200);
                rd(`EIU_OFS_FLAG_BANK, m != 3 ? f : 8'h00);
                wr(`EIU_OFS_FLAG_BANK, ~f);
                rd(`EIU_OFS_FLAG_BANK, m != 3 ? f : 8'h00);
                wr(`EIU_OFS_FLAG_BANK, f);
                pm.drive(10'h300);
                rd(`EIU_OFS_FLAG_BANK, m != 2 ? f : 8'h00);
                wr(`EIU_OFS_FLAG_BANK, f);
                rd(`EIU_OFS_FLAG_BANK, 8'h00);
            end
        end
        $display("t_edge_modes finished");
    endtask

    // Low level on each line requests without a flag, gated by enable.
    task automatic t_level;
        wr(`EIU_OFS_CORE_CTRL, 8'h00);
        wr(`EIU_OFS_EN_MASK, 8'hC0);
        set_gie(1'b1);
        for (int l = 0; l < 2; l++) begin
            pm.drive(l ? 10'h100 : 10'h200);
            #1 `CHK(o_irq_req, 1'b1)
            `CHK(o_irq_vector, l ? EIU_VEC_LINE_B : EIU_VEC_LINE_A)
            rd(`EIU_OFS_FLAG_BANK, 8'h00);
            set_gie(1'b0);
            repeat (2) @(posedge i_clk);
            #1 `CHK(o_irq_req, 1'b0)
            set_gie(1'b1);
            pm.drive(10'h300);
            #1 `CHK(o_irq_req, 1'b0)
        end
        wr(`EIU_OFS_EN_MASK, 8'h00);
        $display("t_level finished");
    endtask

    // Two lines fire together; handler entry clears one flag at a time.
    task automatic t_irq_ack;
        wr(`EIU_OFS_CORE_CTRL, 8'h0E);
        wr(`EIU_OFS_EN_MASK, 8'hC0);
        pm.drive(10'h100);
        pm.drive(10'h200);
        #1 `CHK(o_irq_vector, EIU_VEC_LINE_A)
        ack(EIU_VEC_LINE_A);
        `CHK(o_irq_vector, EIU_VEC_LINE_B)
        ack(EIU_VEC_LINE_B);
        `CHK(o_irq_req, 1'b0)
        rd(`EIU_OFS_FLAG_BANK, 8'h00);
        wr(`EIU_OFS_EN_MASK, 8'h80);
        pm.drive(10'h300);
        pm.drive(10'h200);
        #1 `CHK(o_irq_req, 1'b0)
        rd(`EIU_OFS_FLAG_BANK, 8'h40);
        wr(`EIU_OFS_FLAG_BANK, 8'h40);
        pm.drive(10'h300);
        wr(`EIU_OFS_EN_MASK, 8'h00);
        $display("t_irq_ack finished");
    endtask

    // Masked-off input ignored, masked input requests, then gated off.
    task automatic t_pin_change;
        wr(`EIU_OFS_PC_MASK, 8'h01);
        wr(`EIU_OFS_EN_MASK, 8'h20);
        pm.drive(10'h302);
        #1 `CHK(o_irq_req, 1'b0)
        rd(`EIU_OFS_FLAG_BANK, 8'h00);
        pm.drive(10'h303);
        #1 `CHK(o_irq_vector, EIU_VEC_PIN_CHANGE)
        ack(EIU_VEC_PIN_CHANGE);
        `CHK(o_irq_req, 1'b0)
        set_gie(1'b0);
        pm.drive(10'h302);
        #1 `CHK(o_irq_req, 1'b0)
        rd(`EIU_OFS_FLAG_BANK, 8'h20);
        $display("t_pin_change finished");
    endtask

    // Reset in mid-run wipes the setup and the pending flag.
    task automatic t_reset;
        wr(`EIU_OFS_CORE_CTRL, 8'h05);
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1 `CHK(o_irq_req, 1'b0)
        repeat (3) @(posedge i_clk);
        rd(`EIU_OFS_CORE_CTRL, 8'h00);
        rd(`EIU_OFS_FLAG_BANK, 8'h00);
        rd(`EIU_OFS_EN_MASK, 8'h00);
        $display("t_reset finished");
    endtask

    // Resets the block, then runs every scenario in turn.
    initial begin
        i_clk           = 1'b0;
        i_reset_n       = 1'b0;
        i_addr          = 3'h0;
        i_wdata         = 8'h00;
        i_wr            = 1'b0;
        i_rd            = 1'b0;
        i_global_irq_en = 1'b0;
        i_irq_ack       = 1'b0;
        i_ack_vector    = EIU_VEC_NONE;
        err_total       = 0;
        total_checks    = 0;
        cycles          = 0;
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_regs();
        t_edge_modes();
        t_level();
        t_irq_ack();
        t_pin_change();
        t_reset();
        close_out();
    end
endmodule // eiu_top_test

bind eiu_top eiu_top_asserts u_chk (.i_clk, .i_reset_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_global_irq_en, .i_irq_ack,
    .i_ack_vector, .i_ext_irq_line_a, .i_ext_irq_line_b,
    .i_pin_change_inputs, .o_irq_req, .o_irq_vector);
